// ==== rtl/ucc_defines.vh ====
// Register offsets, field positions, reset values and encodings of the control block
`ifndef UCC_DEFINES_VH
`define UCC_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define UCC_ADDR_W        4
`define UCC_OFF_TXLOW     4'h2
`define UCC_OFF_TXHIGH    4'h3
`define UCC_OFF_CTRL_A    4'h5
`define UCC_OFF_CTRL_B    4'h6
`define UCC_OFF_CTRL_C    4'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define UCC_RST_CTRL_A    8'h00
`define UCC_RST_CTRL_B    8'h00
`define UCC_RST_CTRL_C    8'h03
`define UCC_RST_SPI_C     8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define UCC_A_HALFDUP     0
`define UCC_B_RX_ON       7
`define UCC_B_TX_ON       6
`define UCC_B_SFD         4
`define UCC_B_ODRAIN      3
`define UCC_B_RSPD_HI     2
`define UCC_B_RSPD_LO     1
`define UCC_B_MPROC       0
`define UCC_C_COMM_HI     7
`define UCC_C_COMM_LO     6
`define UCC_C_PAR_HI      5
`define UCC_C_PAR_LO      4
`define UCC_C_STOP        3
`define UCC_C_CHW_HI      2
`define UCC_C_CHW_LO      0
`define UCC_C_ORDER       2
`define UCC_C_PHASE       1

// Writable masks per layout; other bits read zero
`define UCC_MASK_A        8'h01
`define UCC_MASK_B        8'hdf
`define UCC_MASK_SPI      8'hc6

// ****************************************************************
// Encodings
// ****************************************************************
`define UCC_CM_ASYNC      2'h0
`define UCC_CM_SYNC       2'h1
`define UCC_CM_IR         2'h2
`define UCC_CM_SPI        2'h3
`define UCC_RM_NORMAL     2'h0
`define UCC_RM_DOUBLE     2'h1
`define UCC_RM_GENBAUD    2'h2
`define UCC_RM_CONAUTO    2'h3
`define UCC_PAR_OFF       2'h0
`define UCC_PAR_EVEN      2'h2
`define UCC_PAR_ODD       2'h3
`define UCC_CW_9L         3'h6
`define UCC_CW_9H         3'h7
`define UCC_CW_RES4       3'h4
`define UCC_CW_RES5       3'h5
`define UCC_CW_BASE       4'h5
`define UCC_CW_NINE       4'h9
`define UCC_CW_EIGHT      4'h8

`endif

// ==== rtl/ucc_frame_decode.v ====
// Decoder of the frame format fields into settings for the serial engines
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_frame_decode (
  input  wire [1:0] comm_mode,
  input  wire [1:0] parity_select,
  input  wire       stop_bit_count,
  input  wire [2:0] char_width,
  output reg        parity_on,
  output reg        parity_odd,
  output reg  [1:0] stop_bits,
  output reg  [3:0] data_bits,
  output reg        nine_bit_low_first
);

  // Async-style framing; host SPI mode ignores these fields
  always @* begin
    parity_on          = 1'b0;
    parity_odd         = 1'b0;
    stop_bits          = 2'd1;
    data_bits          = `UCC_CW_BASE;
    nine_bit_low_first = 1'b0;
    if (comm_mode != `UCC_CM_SPI) begin
      // Reserved parity code behaves as disabled
      parity_on  = (parity_select == `UCC_PAR_EVEN) ||
                   (parity_select == `UCC_PAR_ODD);
      parity_odd = (parity_select == `UCC_PAR_ODD);
      stop_bits  = stop_bit_count ? 2'd2 : 2'd1;
      case (char_width)
        `UCC_CW_9L: begin
          data_bits          = `UCC_CW_NINE;
          nine_bit_low_first = 1'b1;
        end
        `UCC_CW_9H: data_bits = `UCC_CW_NINE;
        // Reserved sizes fall back to eight bits
        `UCC_CW_RES4, `UCC_CW_RES5: data_bits = `UCC_CW_EIGHT;
        default: data_bits = `UCC_CW_BASE + {2'b00, char_width[1:0]};
      endcase
    end
  end

endmodule // ucc_frame_decode
`default_nettype wire

// ==== rtl/ucc_rx_mode_decode.v ====
// Decoder of the receiver speed mode field into one-hot mode strobes
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_rx_mode_decode (
  input  wire [1:0] receiver_speed_mode,
  input  wire       rx_enable,
  output wire       double_speed,
  output wire       generic_baud_detect,
  output wire       constrained_baud_detect
);

  // Modes only matter while the receiver runs
  assign double_speed            = rx_enable &&
                                   (receiver_speed_mode == `UCC_RM_DOUBLE);
  assign generic_baud_detect     = rx_enable &&
                                   (receiver_speed_mode == `UCC_RM_GENBAUD);
  assign constrained_baud_detect = rx_enable &&
                                   (receiver_speed_mode == `UCC_RM_CONAUTO);

endmodule // ucc_rx_mode_decode
`default_nettype wire

// ==== rtl/ucc_control.v ====
// Control and configuration registers of the serial transceiver
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_control (
  input  wire                   clock,
  input  wire                   srst,
  input  wire [`UCC_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata,
  input  wire                   line_in,
  input  wire                   line_tx_data,
  input  wire                   line_tx_drive,
  output reg                    line_out,
  output reg                    line_oe_n,
  output reg                    line_dir,
  output reg                    rx_active,
  output reg                    tx_active,
  output reg                    rx_line,
  output reg                    frame_start_detect_enable,
  output reg                    multiprocessor_mode,
  output reg                    double_speed,
  output reg                    generic_baud_detect,
  output reg                    constrained_baud_detect,
  output reg  [1:0]             communication_mode_select,
  output reg                    parity_on,
  output reg                    parity_odd,
  output reg  [1:0]             stop_bits,
  output reg  [3:0]             data_bits,
  output reg                    bit_order,
  output reg                    sample_edge_phase,
  output reg                    tx_load,
  output reg  [8:0]             tx_frame
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [7:0] ctrl_a_q;
  reg  [7:0] ctrl_b_q;
  reg  [7:0] ctrl_c_q;
  reg  [7:0] tx_low_q;
  reg        tx_high_q;
  reg        line_meta_q;
  reg        line_sync_q;

  wire       spi_mode;
  wire       hit_a;
  wire       hit_b;
  wire       hit_c;
  wire       hit_low;
  wire       hit_high;
  wire [1:0] new_comm;
  wire       load_by_high;
  wire       dec_par_on;
  wire       dec_par_odd;
  wire [1:0] dec_stop;
  wire [3:0] dec_bits;
  wire       dec_low_first;
  wire       dec_double;
  wire       dec_gen;
  wire       dec_con;
  reg  [7:0] rd_mux;

  // Address decode
  assign spi_mode  = (ctrl_c_q[`UCC_C_COMM_HI:`UCC_C_COMM_LO] == `UCC_CM_SPI);
  assign hit_a     = (addr == `UCC_OFF_CTRL_A);
  assign hit_b     = (addr == `UCC_OFF_CTRL_B);
  assign hit_c     = (addr == `UCC_OFF_CTRL_C);
  assign hit_low   = (addr == `UCC_OFF_TXLOW);
  assign hit_high  = (addr == `UCC_OFF_TXHIGH);
  assign new_comm  = wdata[`UCC_C_COMM_HI:`UCC_C_COMM_LO];

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Each control register has its own process so a strobe to one address
  // can never disturb the others
  always @(posedge clock) begin
    if (srst)
      ctrl_a_q <= `UCC_RST_CTRL_A;
    else if (wr && hit_a)
      ctrl_a_q <= wdata & `UCC_MASK_A;
  end

  // Control B; receiver mode in async or infrared is left to software
  always @(posedge clock) begin
    if (srst)
      ctrl_b_q <= `UCC_RST_CTRL_B;
    else if (wr && hit_b)
      ctrl_b_q <= wdata & `UCC_MASK_B;
  end

  // Control C layout follows the mode being written, so fields outside the
  // SPI layout are cleared on every write of SPI mode; other modes take the whole byte
  always @(posedge clock) begin
    if (srst) begin
      ctrl_c_q <= `UCC_RST_CTRL_C;
    end else if (wr && hit_c) begin
      if (new_comm == `UCC_CM_SPI)
        ctrl_c_q <= wdata & `UCC_MASK_SPI;
      else
        ctrl_c_q <= wdata;
    end
  end

  // Data bytes are kept even while the transmitter is off
  always @(posedge clock) begin
    if (srst) begin
      tx_low_q  <= 8'h00;
      tx_high_q <= 1'b0;
    end else begin
      if (wr && hit_low)
        tx_low_q <= wdata;
      if (wr && hit_high)
        tx_high_q <= wdata[0];
    end
  end

  // ****************************************************************
  // Field decoders
  // ****************************************************************
  ucc_frame_decode u_frame (
    .comm_mode          (ctrl_c_q[`UCC_C_COMM_HI:`UCC_C_COMM_LO]),
    .parity_select      (ctrl_c_q[`UCC_C_PAR_HI:`UCC_C_PAR_LO]),
    .stop_bit_count     (ctrl_c_q[`UCC_C_STOP]),
    .char_width         (ctrl_c_q[`UCC_C_CHW_HI:`UCC_C_CHW_LO]),
    .parity_on          (dec_par_on),
    .parity_odd         (dec_par_odd),
    .stop_bits          (dec_stop),
    .data_bits          (dec_bits),
    .nine_bit_low_first (dec_low_first)
  );

  ucc_rx_mode_decode u_receiver_speed_mode (
    .receiver_speed_mode     (ctrl_b_q[`UCC_B_RSPD_HI:`UCC_B_RSPD_LO]),
    .rx_enable               (ctrl_b_q[`UCC_B_RX_ON]),
    .double_speed            (dec_double),
    .generic_baud_detect     (dec_gen),
    .constrained_baud_detect (dec_con)
  );

  // High byte loads the frame only in nine-bit low-first size
  assign load_by_high = dec_low_first;

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Data registers are write-only here; they read as zero
  always @* begin
    case (addr)
      `UCC_OFF_CTRL_A: rd_mux = ctrl_a_q;
      `UCC_OFF_CTRL_B: rd_mux = ctrl_b_q;
      `UCC_OFF_CTRL_C: rd_mux = spi_mode ? (ctrl_c_q & `UCC_MASK_SPI) : ctrl_c_q;
      default:         rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (srst)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rd_mux;
    else
      rdata <= 8'h00;
  end

  // ****************************************************************
  // Line input synchroniser
  // ****************************************************************
  // Pin is asynchronous; second stage is the only reader of the first
  always @(posedge clock) begin
    if (srst) begin
      line_meta_q <= 1'b1;
      line_sync_q <= 1'b1;
    end else begin
      line_meta_q <= line_in;
      line_sync_q <= line_meta_q;
    end
  end

  // ****************************************************************
  // Registered outputs: enables and mode copies
  // ****************************************************************
  // Every output comes from a flop, one cycle behind the control state
  always @(posedge clock) begin
    if (srst) begin
      rx_active                 <= 1'b0;
      tx_active                 <= 1'b0;
      frame_start_detect_enable <= 1'b0;
      multiprocessor_mode       <= 1'b0;
      double_speed              <= 1'b0;
      generic_baud_detect       <= 1'b0;
      constrained_baud_detect   <= 1'b0;
    end else begin
      rx_active                 <= ctrl_b_q[`UCC_B_RX_ON];
      tx_active                 <= ctrl_b_q[`UCC_B_TX_ON];
      frame_start_detect_enable <= ctrl_b_q[`UCC_B_SFD];
      multiprocessor_mode       <= ctrl_b_q[`UCC_B_MPROC];
      // Speed strobes are already gated by the receiver enable
      double_speed              <= dec_double;
      generic_baud_detect       <= dec_gen;
      constrained_baud_detect   <= dec_con;
    end
  end

  // ****************************************************************
  // Registered outputs: line pin and half-duplex direction
  // ****************************************************************
  // Open drain only pulls low; push-pull drives both levels
  always @(posedge clock) begin
    if (srst) begin
      line_out  <= 1'b1;
      line_oe_n <= 1'b1;
      line_dir  <= 1'b0;
      rx_line   <= 1'b1;
    end else begin
      // Receiver sees idle-high line while disabled
      rx_line <= ctrl_b_q[`UCC_B_RX_ON] ? line_sync_q : 1'b1;
      if (!ctrl_b_q[`UCC_B_TX_ON]) begin
        line_out  <= 1'b1;
        line_oe_n <= 1'b1;
      end else if (ctrl_b_q[`UCC_B_ODRAIN]) begin
        // A released pin relies on the external pull-up for its high
        line_out  <= 1'b0;
        line_oe_n <= line_tx_data;
      end else begin
        line_out  <= line_tx_data;
        line_oe_n <= 1'b0;
      end
      // Half-duplex direction follows the engine drive request
      line_dir <= ctrl_a_q[`UCC_A_HALFDUP] & ctrl_b_q[`UCC_B_TX_ON] & line_tx_drive;
    end
  end

  // ****************************************************************
  // Registered outputs: frame format
  // ****************************************************************
  // Host SPI mode forces plain eight-bit frames without parity
  always @(posedge clock) begin
    if (srst) begin
      communication_mode_select <= `UCC_CM_ASYNC;
      parity_on                 <= 1'b0;
      parity_odd                <= 1'b0;
      stop_bits                 <= 2'd1;
      data_bits                 <= `UCC_CW_EIGHT;
      bit_order                 <= 1'b0;
      sample_edge_phase         <= 1'b0;
    end else begin
      communication_mode_select <= ctrl_c_q[`UCC_C_COMM_HI:`UCC_C_COMM_LO];
      parity_on                 <= dec_par_on;
      parity_odd                <= dec_par_odd;
      stop_bits                 <= dec_stop;
      data_bits                 <= spi_mode ? `UCC_CW_EIGHT : dec_bits;
      // SPI-only fields read as zero outside host SPI mode
      bit_order                 <= spi_mode & ctrl_c_q[`UCC_C_ORDER];
      sample_edge_phase         <= spi_mode & ctrl_c_q[`UCC_C_PHASE];
    end
  end

  // ****************************************************************
  // Registered outputs: transmit frame load
  // ****************************************************************
  // Frame follows written bytes only, so a read never disturbs it
  always @(posedge clock) begin
    if (srst) begin
      tx_load  <= 1'b0;
      tx_frame <= 9'h000;
    end else begin
      // Strobe from the byte that completes the frame, only while enabled
      tx_load  <= wr && ctrl_b_q[`UCC_B_TX_ON] &&
                  (load_by_high ? hit_high : hit_low);
      tx_frame <= {(wr && hit_high) ? wdata[0] : tx_high_q,
                   (wr && hit_low) ? wdata : tx_low_q};
    end
  end

endmodule // ucc_control
`default_nettype wire

// ==== verification/ucc_control_sva.sv ====
// Checker of the control block's port behaviour
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module ucc_control_sva (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic [`UCC_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [7:0]             rdata,
  input wire logic                   line_out,
  input wire logic                   line_oe_n,
  input wire logic                   rx_active,
  input wire logic                   tx_active,
  input wire logic                   rx_line,
  input wire logic                   frame_start_detect_enable,
  input wire logic                   multiprocessor_mode,
  input wire logic                   double_speed,
  input wire logic                   generic_baud_detect,
  input wire logic                   constrained_baud_detect,
  input wire logic [1:0]             communication_mode_select,
  input wire logic                   parity_on,
  input wire logic [1:0]             stop_bits,
  input wire logic [3:0]             data_bits,
  input wire logic                   bit_order,
  input wire logic                   sample_edge_phase,
  input wire logic                   tx_load,
  input wire logic [8:0]             tx_frame
);
  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_wr_b; wr && addr == `UCC_OFF_CTRL_B; endsequence
  sequence s_rd_b; rd && addr == `UCC_OFF_CTRL_B; endsequence
  sequence s_wr_c; wr && addr == `UCC_OFF_CTRL_C && wdata[7:6] != 2'h3; endsequence

  // Register written at the take edge, outputs one edge later
  a_ctrl_b_fields: assert property (s_wr_b |-> ##2
    {rx_active, tx_active, frame_start_detect_enable, multiprocessor_mode} ==
    {$past(wdata[7], 2), $past(wdata[6], 2), $past(wdata[4], 2), $past(wdata[0], 2)})
    else $error("control B outputs wrong");
  a_rx_speed_mode: assert property (s_wr_b |-> ##2
    {constrained_baud_detect, generic_baud_detect, double_speed} == ({3{$past(wdata[7], 2)}} &
    {$past(wdata[2:1], 2) == 2'h3, $past(wdata[2:1], 2) == 2'h2, $past(wdata[2:1], 2) == 2'h1}))
    else $error("receiver speed strobes wrong");
  a_ctrl_b_readback: assert property (s_wr_b ##1 !wr ##1 s_rd_b |=>
    rdata == ($past(wdata, 3) & 8'hdf)) else $error("control B readback wrong");
  a_mode_select: assert property (wr && addr == `UCC_OFF_CTRL_C |-> ##2
    communication_mode_select == $past(wdata[7:6], 2)) else $error("mode select wrong");
  a_stop_count: assert property (s_wr_c |-> ##2
    stop_bits == ($past(wdata[3], 2) ? 2'h2 : 2'h1)) else $error("stop bit count wrong");
  a_char_width: assert property (s_wr_c |-> ##2 data_bits == ($past(wdata[2], 2) ?
    ($past(wdata[1], 2) ? 4'h9 : 4'h8) : (4'h5 + {2'h0, $past(wdata[1:0], 2)})))
    else $error("character width wrong");
  a_spi_layout: assert property (communication_mode_select == 2'h3 |->
    !parity_on && stop_bits == 2'h1 && data_bits == 4'h8) else $error("host SPI layout wrong");
  a_spi_fields_off: assert property (communication_mode_select != 2'h3 |->
    !bit_order && !sample_edge_phase) else $error("order or phase outside host SPI");
  a_load_low_byte: assert property ($past(!wr) && wr && addr == `UCC_OFF_TXLOW &&
    tx_active && data_bits == 4'h8 |=> tx_load && tx_frame[7:0] == $past(wdata))
    else $error("low byte write did not load");
  a_tx_idle_line: assert property (!tx_active && $past(!tx_active) |->
    line_oe_n && line_out) else $error("line driven while transmitter off");
  a_rx_off_line: assert property (!rx_active && $past(!rx_active) |-> rx_line)
    else $error("receiver line moves while off");
endmodule // ucc_control_sva

bind ucc_control ucc_control_sva u_sva (.clock, .srst, .addr, .wdata, .wr, .rd, .rdata,
  .line_out, .line_oe_n, .rx_active, .tx_active, .rx_line, .frame_start_detect_enable,
  .multiprocessor_mode, .double_speed, .generic_baud_detect, .constrained_baud_detect,
  .communication_mode_select, .parity_on, .stop_bits, .data_bits, .bit_order,
  .sample_edge_phase, .tx_load, .tx_frame);
`default_nettype wire

// ==== verification/ucc_peer.sv ====
// Serial peer on the line with the line's pull-up
`timescale 1ns/1ps
`default_nettype none

module ucc_peer (
  input  wire logic line_out,
  input  wire logic line_oe_n,
  input  wire logic pull_low,
  output logic      line_in
);
  // Released line floats to the pull-up level, peer may pull it down
  assign line_in = (line_oe_n ? 1'b1 : line_out) & ~pull_low;
endmodule // ucc_peer
`default_nettype wire

// ==== verification/usart_control_config_tb.sv ====
// Self-checking bench of the control block
`timescale 1ns/1ps
`default_nettype none
`include "ucc_defines.vh"

module usart_control_config_tb;
  localparam logic [3:0] ra = `UCC_OFF_CTRL_A, rb = `UCC_OFF_CTRL_B, rc = `UCC_OFF_CTRL_C;
  localparam logic [3:0] tl = `UCC_OFF_TXLOW, th = `UCC_OFF_TXHIGH;
  logic       clock = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, pull_low = 1'b0;
  logic       line_tx_data = 1'b1, line_tx_drive = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic       line_in, line_out, line_oe_n, line_dir, rx_active, tx_active, rx_line, tx_load;
  logic       frame_start_detect_enable, multiprocessor_mode, double_speed, generic_baud_detect;
  logic       constrained_baud_detect, parity_on, parity_odd, bit_order, sample_edge_phase;
  logic [1:0] communication_mode_select, stop_bits;
  logic [3:0] data_bits;
  logic [8:0] tx_frame;
  logic [3:0] dbw [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9};
  logic [2:0] spd [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int         n_fail = 0, checks_done = 0, cycles = 0, loads = 0;

  ucc_control dut (.clock, .srst, .addr, .wdata, .wr, .rd, .rdata, .line_in, .line_tx_data,
    .line_tx_drive, .line_out, .line_oe_n, .line_dir, .rx_active, .tx_active, .rx_line,
    .frame_start_detect_enable, .multiprocessor_mode, .double_speed, .generic_baud_detect,
    .constrained_baud_detect, .communication_mode_select, .parity_on, .parity_odd, .stop_bits,
    .data_bits, .bit_order, .sample_edge_phase, .tx_load, .tx_frame);
  ucc_peer u_peer (.line_out, .line_oe_n, .pull_low, .line_in);

  // Clock, load pulse count and hang guard; counting high cycles also checks pulse width
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (tx_load === 1'b1) loads <= loads + 1;
    if (cycles == 5000) begin
      n_fail++;
      $display("[FAIL] %0t ns: timeout", $time);
      conclude();
    end
  end

  // ****************************************************************
  // Bus and compare helpers
  // ****************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk({4'h0, rdata}, {4'h0, exp});
  endtask
  // Long enough for register, line sync and output stages
  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask
  function automatic logic [11:0] fmt();
    return {communication_mode_select, parity_on, parity_odd, stop_bits, data_bits,
            bit_order, sample_edge_phase};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals;
    rreg(ra, 8'h00);
    rreg(rb, 8'h00);
    rreg(rc, 8'h03);
    chk(fmt(), {2'h0, 2'h0, 2'h1, 4'h8, 2'h0});
    wreg(4'hf, 8'hff);
    rreg(4'hf, 8'h00);
    $display("test reset_vals done");
  endtask
  task automatic t_ctrl_a;
    wreg(ra, 8'hff);
    rreg(ra, 8'h01);
    wreg(rb, 8'h40);
    line_tx_drive <= 1'b1;
    settle();
    chk({11'h0, line_dir}, 12'h001);
    wreg(ra, 8'h00);
    settle();
    chk({11'h0, line_dir}, 12'h000);
    $display("test ctrl_a done");
  endtask
  task automatic t_ctrl_b;
    logic [7:0] d;
    wreg(rc, 8'h43);
    for (int m = 0; m < 4; m++) begin
      d = {1'b1, m[1], 1'b1, m[0], 1'b0, m[1:0], ~m[0]};
      wreg(rb, d);
      rreg(rb, d & 8'hdf);
      settle();
      chk({8'h0, rx_active, tx_active, frame_start_detect_enable, multiprocessor_mode},
          {8'h0, 1'b1, d[6], d[4], d[0]});
      chk({9'h0, constrained_baud_detect, generic_baud_detect, double_speed}, {9'h0, spd[m]});
    end
    wreg(rb, 8'h22);
    rreg(rb, 8'h02);
    settle();
    chk({9'h0, constrained_baud_detect, generic_baud_detect, double_speed}, 12'h000);
    wreg(rb, 8'h00);
    $display("test ctrl_b done");
  endtask
  task automatic t_ctrl_c;
    logic [7:0] d;
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      d = {1'b0, i[0], i[1:0], i[2], i};
      wreg(rc, d);
      rreg(rc, d);
      settle();
      chk(fmt(), {1'b0, i[0], i[1], i[1] & i[0], i[2] ? 2'h2 : 2'h1, dbw[i], 2'h0});
    end
    $display("test ctrl_c done");
  endtask
  task automatic t_spi;
    wreg(rc, 8'hff);
    rreg(rc, 8'hc6);
    settle();
    chk(fmt(), {2'h3, 2'h0, 2'h1, 4'h8, 2'h3});
    wreg(rc, 8'hc2);
    settle();
    chk(fmt(), {2'h3, 2'h0, 2'h1, 4'h8, 2'h1});
    wreg(rc, 8'hbf);
    rreg(rc, 8'hbf);
    settle();
    chk(fmt(), {2'h2, 2'h3, 2'h2, 4'h9, 2'h0});
    $display("test spi done");
  endtask
  task automatic t_tx;
    int n;
    wreg(rb, 8'h40);
    wreg(rc, 8'h07);
    n = loads;
    wreg(th, 8'h01);
    wreg(tl, 8'haa);
    settle();
    chk({2'h0, tx_frame, 1'(loads - n)}, {2'h0, 9'h1aa, 1'b1});
    wreg(rc, 8'h06);
    wreg(tl, 8'h55);
    settle();
    chk(12'(loads - n), 12'h001);
    wreg(th, 8'h00);
    settle();
    chk({1'b0, tx_frame, 2'(loads - n)}, {1'b0, 9'h055, 2'h2});
    wreg(rc, 8'h03);
    wreg(tl, 8'h3c);
    wreg(rb, 8'h00);
    wreg(tl, 8'h11);
    settle();
    chk({1'b0, tx_frame, 2'(loads - n)}, {1'b0, 9'h011, 2'h3});
    $display("test tx done");
  endtask
  task automatic t_line;
    wreg(rb, 8'hc0);
    line_tx_data <= 1'b0;
    settle();
    chk({9'h0, line_oe_n, line_out, rx_line}, 12'h000);
    wreg(rb, 8'hc8);
    line_tx_data <= 1'b1;
    settle();
    chk({9'h0, line_oe_n, line_out, rx_line}, 12'h005);
    @(posedge clock) pull_low <= 1'b1;
    settle();
    chk({9'h0, line_oe_n, line_out, rx_line}, 12'h004);
    wreg(rb, 8'h48);
    settle();
    chk({11'h0, rx_line}, 12'h001);
    wreg(rb, 8'h80);
    settle();
    chk({9'h0, line_oe_n, line_out, rx_line}, 12'h006);
    @(posedge clock) pull_low <= 1'b0;
    $display("test line done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_reset_vals();
    t_ctrl_a();
    t_ctrl_b();
    t_ctrl_c();
    t_spi();
    t_tx();
    t_line();
    conclude();
  end
endmodule // usart_control_config_tb
`default_nettype wire
